// [core/limit_channel.sv]
/*
 * One supervision channel: compares a sample against low/high limits with hysteresis
 * and produces the out-of-limit flag and warning/fault levels.
 * Assumes all inputs come from logic on ref_clk and rst_n is already synchronised.
 */
`timescale 1ns/1ns
`default_nettype none

module limit_channel
    import sup_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Sample
    input wire logic sample,
    input wire logic signed [31:0] value,
    // Settings
    input wire mode_type mode,
    input wire action_type action,
    input wire logic signed [31:0] low,
    input wire logic signed [31:0] high,
    input wire logic signed [31:0] hyst,
    input wire logic running,
    // Results
    output logic flag,
    output logic warn,
    output logic fault
);
    typedef struct packed {
        logic flag;
        logic warn;
        logic fault;
    } chan_state_type;

    chan_state_type state;
    chan_state_type next_state;
    logic signed [33:0] v, lo, hi, hh, av, alo, ahi;
    logic lo_out, lo_in, hi_out, hi_in, alo_out, alo_in, ahi_out, ahi_in;
    logic set_c, clr_c;

    function automatic logic signed [33:0] mag(input logic signed [33:0] x);
        mag = (x < 34'sh0) ? -x : x;
    endfunction : mag

    // Widen to 34 bits so magnitudes and limit offsets never overflow
    always_comb begin
        v = 34'(value);
        lo = 34'(low);
        hi = 34'(high);
        hh = 34'(hyst) >>> 1; // Half the hysteresis
        av = mag(v);
        alo = mag(lo);
        ahi = mag(hi);
    end

    // Set and clear thresholds, offset by half the hysteresis
    always_comb begin
        lo_out = v < lo - hh;
        lo_in = v > lo + hh;
        hi_out = v > hi + hh;
        hi_in = v < hi - hh;
        alo_out = av < alo - hh;
        alo_in = av > alo + hh;
        ahi_out = av > ahi + hh;
        ahi_in = av < ahi - hh;
    end

    // Mode decode into set and clear conditions
    always_comb begin
        set_c = 1'b0;
        clr_c = 1'b0;
        unique case (mode)
            MODE_OFF: begin
                set_c = 1'b0;
                clr_c = 1'b1;
            end
            MODE_LOW: begin
                set_c = lo_out;
                clr_c = lo_in;
            end
            MODE_HIGH: begin
                set_c = hi_out;
                clr_c = hi_in;
            end
            MODE_ABS_LOW: begin
                set_c = alo_out;
                clr_c = alo_in;
            end
            MODE_ABS_HIGH: begin
                set_c = ahi_out;
                clr_c = ahi_in;
            end
            MODE_BOTH: begin
                set_c = lo_out || hi_out;
                clr_c = lo_in && hi_in;
            end
            MODE_ABS_BOTH: begin
                set_c = alo_out || ahi_out;
                clr_c = alo_in && ahi_in;
            end
            MODE_HYST: begin
                set_c = hi_out;
                clr_c = lo_out;
            end
        endcase
    end

    // Flag moves only on a sample, except that mode off clears it at once; actions follow the flag in the same edge
    always_comb begin
        next_state = state;
        if (mode == MODE_OFF) begin
            next_state.flag = 1'b0;
        end else if (sample) begin
            next_state.flag = state.flag ? !clr_c : set_c;
        end
        next_state.warn = next_state.flag && (action == ACT_WARN);
        next_state.fault = next_state.flag && ((action == ACT_FAULT) ||
            ((action == ACT_FAULT_RUN) && running));
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flag = state.flag;
    assign warn = state.warn;
    assign fault = state.fault;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    disabled_quiet_a:
        assert property (mode == MODE_OFF |=> !flag && !warn && !fault)
        else $error("disabled channel raised a flag or event");
    low_set_a:
        assert property (sample && mode == MODE_LOW && !flag && v < lo - hh |=> flag)
        else $error("low mode did not flag");
    high_set_a:
        assert property (sample && mode == MODE_HIGH && !flag && v > hi + hh |=> flag)
        else $error("high mode did not flag");
    abs_low_a:
        assert property (sample && mode == MODE_ABS_LOW && !flag && av < alo - hh |=> flag)
        else $error("abs low mode did not flag");
    abs_high_a:
        assert property (sample && mode == MODE_ABS_HIGH && !flag && av > ahi + hh |=> flag)
        else $error("abs high mode did not flag");
    both_set_a:
        assert property (sample && mode == MODE_BOTH && !flag && (v < lo - hh || v > hi + hh)
            |=> flag)
        else $error("both mode did not flag");
    abs_both_a:
        assert property (sample && mode == MODE_ABS_BOTH && !flag &&
            (av < alo - hh || av > ahi + hh) |=> flag)
        else $error("abs both mode did not flag");
    hyst_set_a:
        assert property (sample && mode == MODE_HYST && !flag && v > hi + hh |=> flag)
        else $error("hysteresis mode did not set");
    hyst_hold_a:
        assert property (sample && mode == MODE_HYST && flag && !(v < lo - hh) |=> flag)
        else $error("hysteresis flag dropped early");
    hyst_clear_a:
        assert property (sample && mode == MODE_HYST && flag && v < lo - hh |=> !flag)
        else $error("hysteresis flag did not clear");
    hyst_margin_a:
        assert property (sample && mode == MODE_HIGH && !flag && !(v > hi + hh) |=> !flag)
        else $error("high mode ignored hysteresis margin");
    flag_hold_a:
        assert property (!sample && mode != MODE_OFF |=> $stable(flag))
        else $error("flag moved without a sample");
    fault_code_a:
        assert property (next_state.flag && action == ACT_FAULT_RUN |=> fault == $past(running))
        else $error("fault-if-running action wrong");
    warn_code_a:
        assert property (warn |-> flag && $past(action) == ACT_WARN)
        else $error("warning without warn action");
endmodule : limit_channel

`default_nettype wire

// [core/rst_sync.sv]
/*
 * Reset release synchroniser: asynchronous assert, release after two clock edges.
 * Assumes an active low asynchronous reset input.
 */
`timescale 1ns/1ns
`default_nettype none

module rst_sync (
    // Clock and raw reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Synchronised reset
    output logic rst_n
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } sync_state_type;

    sync_state_type state;
    sync_state_type next_state;

    // Shift a one through after release; only stage2 is read outside
    always_comb begin
        next_state.stage1 = 1'b1;
        next_state.stage2 = state.stage1;
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rst_n = state.stage2;
endmodule : rst_sync

`default_nettype wire

// [core/signal_limit_supervisor.sv]
/*
 * Signal limit supervisor: six channels of limit comparison behind an APB slave,
 * with a status word and warning/fault levels per channel.
 * Assumes monitored values, sample strobe and motor running come from logic on ref_clk;
 * arst_n may be asynchronous and is released through two flip-flops here.
 */
// Functional notes
// - Mode 0 disables the channel; no flag, no action ever.
// - Mode 1 flags when value is below low limit.
// - Mode 2 flags when value is above high limit.
// - Mode 3 flags when magnitude is below magnitude of low limit.
// - Mode 4 flags when magnitude is above magnitude of high limit.
// - Mode 5 flags when value is below low or above high.
// - Mode 6 flags when magnitude below abs low or above abs high.
// - Mode 7 sets once value exceeds high plus half hysteresis.
// - Mode 7 holds until value falls below low minus half hysteresis.
// - Hysteresis margin applies in every comparison mode.
// - Action selection never changes the status flag.
// - Action codes: 0 none, 1 warning, 2 fault, 3 fault while running.
// - Status word holds one bit per channel from bit 0; upper bits zero.
`timescale 1ns/1ns
`default_nettype none
`include "supervisor_defines.svh"

module signal_limit_supervisor
    import sup_pkg::*;
#(
    parameter int CHANNELS = 6
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic [`SUP_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Monitored values
    input wire logic sample,
    input wire logic [CHANNELS-1:0][31:0] value,
    input wire logic motor_running,
    // Results
    output logic [CHANNELS-1:0] status,
    output logic [CHANNELS-1:0] warn,
    output logic [CHANNELS-1:0] fault
);
    typedef struct packed {
        logic [CHANNELS-1:0][2:0] mode;
        logic [CHANNELS-1:0][1:0] action;
        logic [CHANNELS-1:0][31:0] low;
        logic [CHANNELS-1:0][31:0] high;
        logic [CHANNELS-1:0][31:0] hyst;
        logic [31:0] rdata;
        logic slverr;
    } regs_type;

    regs_type regs;
    regs_type next_regs;
    logic rst_n;
    logic [2:0] ch;
    logic [3:0] sel;
    logic ch_hit;
    logic word_ok;
    logic setup;
    logic access_wr;
    logic [31:0] rd;
    logic hit;

    // Reset release
    rst_sync u_rst_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .rst_n(rst_n)
    );

    // Address split: channel block and register within it
    always_comb begin
        ch = paddr[`SUP_CH_STRIDE_LSB +: 3];
        sel = paddr[3:0];
        word_ok = (paddr[1:0] == 2'h0);
        ch_hit = word_ok && (ch < 3'(CHANNELS)) && (paddr[7] == 1'b0);
        setup = psel && !penable;
        access_wr = psel && penable && pwrite;
    end

    // Read decode, captured in the setup cycle so prdata comes from a flop
    always_comb begin
        rd = 32'h0000_0000;
        hit = 1'b0;
        if (ch_hit) begin
            hit = 1'b1;
            case (sel)
                `SUP_CTRL_OFF: begin
                    rd[`SUP_MODE_LSB +: 3] = regs.mode[ch];
                    rd[`SUP_ACTION_LSB +: 2] = regs.action[ch];
                end
                `SUP_LOW_OFF: rd = regs.low[ch];
                `SUP_HIGH_OFF: rd = regs.high[ch];
                default: rd = regs.hyst[ch];
            endcase
        end else if (paddr == `SUP_STATUS_OFF) begin
            hit = 1'b1;
            rd[CHANNELS-1:0] = status;
        end else if (paddr == `SUP_EVENT_OFF) begin
            hit = 1'b1;
            rd[`SUP_WARN_LSB +: CHANNELS] = warn;
            rd[`SUP_FAULT_LSB +: CHANNELS] = fault;
        end
    end

    // Register writes in the access phase; read data and error in setup
    always_comb begin
        next_regs = regs;
        if (setup) begin
            next_regs.rdata = pwrite ? 32'h0000_0000 : rd;
            next_regs.slverr = !hit || (pwrite && !ch_hit);
        end
        if (access_wr && ch_hit) begin
            case (sel)
                `SUP_CTRL_OFF: begin
                    next_regs.mode[ch] = pwdata[`SUP_MODE_LSB +: 3];
                    next_regs.action[ch] = pwdata[`SUP_ACTION_LSB +: 2];
                end
                `SUP_LOW_OFF: next_regs.low[ch] = pwdata;
                `SUP_HIGH_OFF: next_regs.high[ch] = pwdata;
                default: next_regs.hyst[ch] = pwdata;
            endcase
        end
    end

    // Register file
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regs.mode <= {CHANNELS{`SUP_MODE_RST}};
            regs.action <= {CHANNELS{`SUP_ACTION_RST}};
            regs.low <= {CHANNELS{`SUP_LIMIT_RST}};
            regs.high <= {CHANNELS{`SUP_LIMIT_RST}};
            regs.hyst <= {CHANNELS{`SUP_LIMIT_RST}};
            regs.rdata <= 32'h0000_0000;
            regs.slverr <= 1'b0;
        end else begin
            regs <= next_regs;
        end
    end

    // Zero wait states; error shown only in the access phase
    assign pready = 1'b1;
    assign prdata = regs.rdata;
    assign pslverr = psel && penable && regs.slverr;

    // One comparator per channel
    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++) begin : g_chan
            limit_channel u_chan (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .sample(sample),
                .value(value[i]),
                .mode(mode_type'(regs.mode[i])),
                .action(action_type'(regs.action[i])),
                .low(regs.low[i]),
                .high(regs.high[i]),
                .hyst(regs.hyst[i]),
                .running(motor_running),
                .flag(status[i]),
                .warn(warn[i]),
                .fault(fault[i])
            );
        end
    endgenerate

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    status_word_a:
        assert property (setup && !pwrite && paddr == `SUP_STATUS_OFF
            |=> prdata == 32'($past(status)))
        else $error("status word read wrong");
    ctrl_write_a:
        assert property (access_wr && paddr == 8'h00
            |=> regs.action[0] == $past(pwdata[`SUP_ACTION_LSB +: 2]) &&
                regs.mode[0] == $past(pwdata[`SUP_MODE_LSB +: 3]))
        else $error("control write not stored");
    unmapped_err_a:
        assert property (setup && paddr == 8'h7c |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped address not refused");
    event_read_a:
        assert property (setup && !pwrite && paddr == `SUP_EVENT_OFF
            |=> prdata[`SUP_FAULT_LSB +: CHANNELS] == $past(fault))
        else $error("event word read wrong");
    mode_off_a:
        assert property (access_wr && paddr == 8'h00 && pwdata[2:0] == 3'h0
            ##1 regs.mode[0] == 3'h0 |=> !status[0])
        else $error("disabled channel still flagged");
    events_need_flag_a:
        assert property ((warn | fault) != '0 |-> ((warn | fault) & ~status) == '0)
        else $error("event without status flag");
endmodule : signal_limit_supervisor

`default_nettype wire

// [inc/sup_pkg.sv]
/*
 * Types shared by the signal limit supervisor: comparison modes and actions.
 * Assumes nothing of its surroundings.
 */
package sup_pkg;

    // Comparison mode codes
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_LOW = 3'h1,
        MODE_HIGH = 3'h2,
        MODE_ABS_LOW = 3'h3,
        MODE_ABS_HIGH = 3'h4,
        MODE_BOTH = 3'h5,
        MODE_ABS_BOTH = 3'h6,
        MODE_HYST = 3'h7
    } mode_type;

    // Action codes
    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_WARN = 2'h1,
        ACT_FAULT = 2'h2,
        ACT_FAULT_RUN = 2'h3
    } action_type;

endpackage : sup_pkg

// [inc/supervisor_defines.svh]
/*
 * Register offsets, field positions and reset values of the signal limit supervisor.
 * Assumes byte addressing on an APB bus with one 32-bit word per register.
 */
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

// Address width and per-channel register block
`define SUP_ADDR_W 8
`define SUP_CH_STRIDE_LSB 4
`define SUP_CTRL_OFF 4'h0
`define SUP_LOW_OFF 4'h4
`define SUP_HIGH_OFF 4'h8
`define SUP_HYST_OFF 4'hc

// Shared registers
`define SUP_STATUS_OFF 8'h60
`define SUP_EVENT_OFF 8'h64

// Field positions
`define SUP_MODE_LSB 0
`define SUP_ACTION_LSB 4
`define SUP_WARN_LSB 0
`define SUP_FAULT_LSB 16

// Reset values
`define SUP_MODE_RST 3'h0
`define SUP_ACTION_RST 2'h0
`define SUP_LIMIT_RST 32'h0000_0000

`endif

// [test/signal_limit_supervisor_bench.sv]
/*
 * Self-checking bench for the signal limit supervisor: register access over APB,
 * seeded random limit checks on all six channels, corner values and refused accesses.
 * Assumes the design on a 50 ns clock with zero-wait APB and a one-cycle sample pulse.
 */
`timescale 1ns/1ns
`default_nettype none
`include "supervisor_defines.svh"

module signal_limit_supervisor_bench
    import sup_pkg::*;
;
    localparam int CH = 6;
    logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, sample, motor_running;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [CH-1:0][31:0] value;
    logic [CH-1:0] status, warn, fault, m_flag;
    logic [2:0] m_mode [CH];
    logic [1:0] m_act [CH];
    logic [31:0] m_low [CH], m_high [CH], m_hyst [CH];
    logic err;
    int n_mismatch = 0;
    int check_count = 0;

    // Design under test
    signal_limit_supervisor #(.CHANNELS(CH)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample(sample), .value(value),
        .motor_running(motor_running), .status(status), .warn(warn), .fault(fault));

    // Clock generation
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Compare one value and count it
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Counts, verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rdata, output logic slverr);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check("pready", 32'h0, 32'h1);
        rdata = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Next flag of one channel, with the hysteresis band holding the old state
    function automatic logic flag_next(logic [2:0] m, logic [31:0] vv, logic [31:0] lo_r,
                                       logic [31:0] hi_r, logic [31:0] hy_r, logic prev);
        longint v, lo, hi, h2;
        logic s, c;
        v = longint'($signed(vv));
        lo = longint'($signed(lo_r));
        hi = longint'($signed(hi_r));
        h2 = longint'($signed(hy_r)) >>> 1;
        if (m == 3'h3 || m == 3'h4 || m == 3'h6) begin
            v = (v < 0) ? -v : v;
            lo = (lo < 0) ? -lo : lo;
            hi = (hi < 0) ? -hi : hi;
        end
        case (m)
            3'h1, 3'h3: begin
                s = v < lo - h2;
                c = v > lo + h2;
            end
            3'h2, 3'h4: begin
                s = v > hi + h2;
                c = v < hi - h2;
            end
            3'h5, 3'h6: begin
                s = v < lo - h2 || v > hi + h2;
                c = v > lo + h2 && v < hi - h2;
            end
            3'h7: begin
                s = v > hi + h2;
                c = v < lo - h2;
            end
            default: return 1'b0;
        endcase
        return s ? 1'b1 : (c ? 1'b0 : prev);
    endfunction : flag_next

    // Program one channel, passing through mode 0 so the flag starts clear
    task automatic setup_ch(input int i, input logic [2:0] m, input logic [1:0] a,
                            input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] hy);
        logic [7:0] base;
        base = 8'(i * 16);
        apb(1'b1, base, 32'h0, rd, err);
        apb(1'b1, base + 8'h4, lo, rd, err);
        apb(1'b1, base + 8'h8, hi, rd, err);
        apb(1'b1, base + 8'hc, hy, rd, err);
        apb(1'b1, base, {26'h0, a, 1'b0, m}, rd, err);
        apb(1'b0, base, 32'h0, rd, err);
        check("ctrl readback", rd, {26'h0, a, 1'b0, m});
        m_flag[i] = 1'b0;
        m_mode[i] = m;
        m_act[i] = a;
        m_low[i] = lo;
        m_high[i] = hi;
        m_hyst[i] = hy;
    endtask : setup_ch

    // Pulse sample with given values, then compare flags, events and status words
    task automatic sample_check(input logic [CH-1:0][31:0] v, input logic run);
        logic [CH-1:0] w, f;
        @(posedge ref_clk);
        sample <= 1'b1;
        value <= v;
        motor_running <= run;
        @(posedge ref_clk);
        sample <= 1'b0;
        value <= ~v;
        for (int i = 0; i < CH; i++) begin
            m_flag[i] = flag_next(m_mode[i], v[i], m_low[i], m_high[i], m_hyst[i], m_flag[i]);
            w[i] = m_flag[i] && m_act[i] == 2'h1;
            f[i] = m_flag[i] && (m_act[i] == 2'h2 || (m_act[i] == 2'h3 && run));
        end
        repeat (3) @(posedge ref_clk);
        check("status port", 32'(status), 32'(m_flag));
        check("warn port", 32'(warn), 32'(w));
        check("fault port", 32'(fault), 32'(f));
        apb(1'b0, `SUP_STATUS_OFF, 32'h0, rd, err);
        check("status word", rd, {26'h0, m_flag});
        apb(1'b0, `SUP_EVENT_OFF, 32'h0, rd, err);
        check("event word", rd, {10'h0, f, 10'h0, w});
    endtask : sample_check

    // Main sequence
    initial begin
        logic [CH-1:0][31:0] v;
        int a, b;
        logic run;
        {arst_n, psel, penable, pwrite, sample, motor_running} = '0;
        paddr = '0;
        pwdata = '0;
        value = '0;
        m_flag = '0;
        void'($urandom(32'hdd1ccfe9));
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Every register reads zero after reset
        for (int k = 0; k < 26; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0, rd, err);
            check("reset value", rd, 32'h0);
            check("reset err", 32'(err), 32'h0);
        end
        $display("test reset_values done");
        // Refused accesses: read-only status, unmapped and misaligned addresses
        apb(1'b1, `SUP_STATUS_OFF, 32'hffff_ffff, rd, err);
        check("ro write err", 32'(err), 32'h1);
        apb(1'b0, 8'h7c, 32'h0, rd, err);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b0, 8'h05, 32'h0, rd, err);
        check("misaligned err", 32'(err), 32'h1);
        apb(1'b0, `SUP_STATUS_OFF, 32'h0, rd, err);
        check("status after ro write", rd, 32'h0);
        $display("test refused done");
        // Magnitude at the edge of the signed range, and mode 7 set, hold and clear on channel 2
        for (int i = 0; i < CH; i++) begin
            m_mode[i] = 3'h0;
            m_act[i] = 2'h0;
            m_low[i] = 32'h0;
            m_high[i] = 32'h0;
            m_hyst[i] = 32'h0;
        end
        setup_ch(0, 3'h4, 2'h2, 32'h0, 32'h7fff_ffff, 32'h0);
        setup_ch(1, 3'h3, 2'h1, 32'h8000_0000, 32'h0, 32'h0);
        setup_ch(2, 3'h7, 2'h3, 32'hffff_fff6, 32'h0000_000a, 32'h0000_0014);
        v = '0;
        v[0] = 32'h8000_0000;
        v[1] = 32'h7fff_ffff;
        v[2] = 32'h0000_0015;
        sample_check(v, 1'b1);
        v[2] = 32'hffff_fff0;
        sample_check(v, 1'b0);
        v[2] = 32'hffff_ffeb;
        sample_check(v, 1'b1);
        $display("test corners done");
        // Random limits and values across every mode and action code
        for (int it = 0; it < 96; it++) begin
            a = int'($urandom_range(200)) - 100;
            b = int'($urandom_range(200)) - 100;
            if (a > b) begin
                a = a ^ b;
                b = a ^ b;
                a = a ^ b;
            end
            setup_ch(it % CH, 3'(it % 8), 2'((it / 8) % 4), 32'(a), 32'(b),
                     32'($urandom_range(60)));
            for (int s = 0; s < 3; s++) begin
                for (int i = 0; i < CH; i++) begin
                    v[i] = 32'(int'($urandom_range(300)) - 150);
                    if ($urandom_range(3) == 0) begin
                        v[i] = ($urandom_range(1) == 0) ? m_low[i] : m_high[i];
                    end
                end
                run = 1'($urandom_range(1));
                sample_check(v, run);
            end
        end
        $display("test random done");
        report_and_stop();
    end

    // Watchdog
    initial begin
        #3_000_000;
        n_mismatch++;
        report_and_stop();
    end

endmodule : signal_limit_supervisor_bench
`default_nettype wire
